//--- psc_pin_state.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module psc_pin_state
  import psc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       chip_init_n,
  input  wire logic                       standby_request_n,
  input  wire logic [2:0]                 mode,
  input  wire logic                       bus16,
  input  psc_op_t                         op_state,
  input  psc_phase_t                      bus_phase,
  input  wire logic                       two_state_area,
  input  psc_bus_t                        core_bus,
  input  wire logic                       watchdog_overflow,
  input  wire logic [3:0]                 timer_oe,
  input  wire logic [3:0]                 timer_out,
  input  wire logic [RA_W-1:0]            reg_addr,
  input  wire logic [RD_W-1:0]            reg_wdata,
  input  wire logic                       reg_we,
  input  wire logic                       reg_re,
  output      logic [RD_W-1:0]            reg_rdata,
  output      logic                       clk_out_oe,
  output      logic                       clk_out_hold_high,
  output      logic                       watchdog_reset_out,
  output      logic                       watchdog_reset_out_oe,
  output      logic [ADDR_W-1:0]          addr_o,
  output      logic                       addr_oe,
  output      logic [7:0]                 data_hi_o,
  output      logic                       data_hi_oe,
  output      psc_strobe_t                strobe_o,
  output      logic                       strobe_oe,
  input  wire logic [NPORT-1:0][PW-1:0]   port_i,
  output      logic [NPORT-1:0][PW-1:0]   port_o,
  output      logic [NPORT-1:0][PW-1:0]   port_oe,
  input  wire logic [PW-1:0]              p7_i
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_expanded34(input logic [2:0] m);
    return (m == 3'h3) || (m == 3'h4);
  endfunction : is_expanded34

  function automatic logic [PW-1:0] port_mask(input int k);
    case (k)
      P_P4:    return P4_MASK;
      P_P6:    return P6_MASK;
      P_P8:    return P8_MASK;
      P_P9:    return P9_MASK;
      P_PA:    return PA_MASK;
      default: return PB_MASK;
    endcase
  endfunction : port_mask

  // ----------------------------------------------------------------
  // reset pin sampling on the falling edge
  // ----------------------------------------------------------------
  logic init_meta_q;
  logic init_low_q;

  always_ff @(negedge clk) begin
    if (!rst_n) begin
      init_meta_q <= 1'b1;
      init_low_q  <= 1'b0;
    end else begin
      init_meta_q <= chip_init_n;
      init_low_q  <= ~init_meta_q;
    end
  end

  // raw pin forces pins safe at once; it reaches flip-flops only in the keep cell
  logic init_raw;
  logic in_reset;
  assign init_raw = ~chip_init_n;
  assign in_reset = init_raw | init_low_q;

  // ----------------------------------------------------------------
  // standby pin synchroniser
  // ----------------------------------------------------------------
  logic standby_request_n_meta_q;
  logic standby_request_n_low_q;
  logic standby_request_n_low_d1_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_request_n_meta_q   <= 1'b1;
      standby_request_n_low_q    <= 1'b0;
      standby_request_n_low_d1_q <= 1'b0;
    end else begin
      standby_request_n_meta_q   <= standby_request_n;
      standby_request_n_low_q    <= ~standby_request_n_meta_q;
      standby_request_n_low_d1_q <= standby_request_n_low_q;
    end
  end

  logic hw_standby_request_n;
  assign hw_standby_request_n = standby_request_n_low_q;

  // ----------------------------------------------------------------
  // address bus behaviour across a reset
  // ----------------------------------------------------------------
  psc_rst_t          rs_q;
  logic [ADDR_W-1:0] addr_hold_q;
  logic              hold_case;

  assign hold_case = (bus_phase == PH_T3) || ((bus_phase == PH_T2) && two_state_area);

  // the sample lands on a falling edge, this edge is half a state later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_q <= RS_RUN;
    end else begin
      case (rs_q)
        RS_RUN: begin
          if (init_low_q && hold_case) begin
            rs_q <= RS_HOLD;
          end else if (init_low_q) begin
            rs_q <= RS_LOW;
          end
        end
        RS_HOLD: rs_q <= RS_LOW;
        RS_LOW: begin
          if (!init_low_q) begin
            rs_q <= RS_RUN;
          end
        end
        default: rs_q <= RS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_hold_q <= '0;
    end else if (rs_q == RS_RUN) begin
      addr_hold_q <= core_bus.addr[ADDR_W-1:0];
    end
  end

  logic bus_float;
  assign bus_float = hw_standby_request_n || (!in_reset && (op_state == OP_SWSTBY || op_state == OP_BUSREL));

  always_comb begin
    case (rs_q)
      RS_HOLD: addr_o = addr_hold_q;
      RS_LOW:  addr_o = '0;
      default: addr_o = core_bus.addr[ADDR_W-1:0];
    endcase
  end

  assign addr_oe    = ~bus_float;
  assign strobe_oe  = ~bus_float;
  assign strobe_o   = in_reset ? '1 : core_bus.strobe;
  assign data_hi_o  = core_bus.dout[15:8];
  assign data_hi_oe = core_bus.data_oe & ~in_reset & ~bus_float;

  assign clk_out_oe            = ~hw_standby_request_n;
  assign clk_out_hold_high     = ~in_reset & (op_state == OP_SWSTBY);
  assign watchdog_reset_out    = 1'b0;
  assign watchdog_reset_out_oe = watchdog_overflow & ~hw_standby_request_n;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [NPORT-1:0][PW-1:0] ddr_q;
  logic [NPORT-1:0][PW-1:0] dr_q;
  logic [RD_W-1:0]          ctrl_q;
  logic                     bus_release_enable;
  logic                     ram_en;
  logic [PA_ADDR_BITS-1:0]  aen;

  assign bus_release_enable   = ctrl_q[CTRL_BUS_RELEASE_ENABLE];
  assign ram_en = ctrl_q[CTRL_ONCHIP_MEMORY_ENABLE];
  assign aen    = ctrl_q[CTRL_AEN_LSB +: PA_ADDR_BITS];

  for (genvar k = 0; k < NPORT; k++) begin : g_port_regs
    localparam logic [RA_W-1:0] DDR_IDX = RA_W'(2 * k) + REG_DDR_BASE;
    localparam logic [RA_W-1:0] DR_IDX  = RA_W'(2 * k + 1) + REG_DDR_BASE;
    localparam logic [PW-1:0]   WMASK   = (k == P_P6) ? (port_mask(k) & ~(PW'(1) << WAIT_BIT))
                                                     : port_mask(k);
    always_ff @(posedge clk) begin
      if (!rst_n || init_low_q) begin
        ddr_q[k] <= '0;
      end else if (reg_we && reg_addr == DDR_IDX) begin
        ddr_q[k] <= reg_wdata & WMASK;
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_n || init_low_q) begin
        dr_q[k] <= '0;
      end else if (reg_we && reg_addr == DR_IDX) begin
        dr_q[k] <= reg_wdata & port_mask(k);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || init_low_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_we && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata & CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // standby entry and exit lead checks
  // ----------------------------------------------------------------
  logic [LEAD_CNT_W-1:0] lead_cnt_q;
  logic                  ret_ok_q;
  logic                  rec_ok_q;

  always_ff @(posedge clk) begin
    if (!rst_n || !init_low_q) begin
      lead_cnt_q <= '0;
    end else if (lead_cnt_q != LEAD_CNT_MAX) begin
      lead_cnt_q <= lead_cnt_q + LEAD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_ok_q <= 1'b1;
      rec_ok_q <= 1'b1;
    end else begin
      if (standby_request_n_low_q && !standby_request_n_low_d1_q) begin
        ret_ok_q <= !ram_en || (lead_cnt_q >= RES_LEAD_CNT);
      end
      if (!standby_request_n_low_q && standby_request_n_low_d1_q) begin
        rec_ok_q <= lead_cnt_q >= REC_LEAD_CNT;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers for read-back
  // ----------------------------------------------------------------
  logic [NPORT-1:0][PW-1:0] pin_meta_q;
  logic [NPORT-1:0][PW-1:0] pin_sync_q;
  logic [PW-1:0]            p7_meta_q;
  logic [PW-1:0]            p7_sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      p7_meta_q  <= '0;
      p7_sync_q  <= '0;
    end else begin
      pin_meta_q <= port_i;
      pin_sync_q <= pin_meta_q;
      p7_meta_q  <= p7_i;
      p7_sync_q  <= p7_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [RD_W-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    if (reg_addr < REG_CTRL) begin
      if (reg_addr[0]) begin
        rd_d = (ddr_q[reg_addr[RA_W-1:1]] & dr_q[reg_addr[RA_W-1:1]])
             | (~ddr_q[reg_addr[RA_W-1:1]] & pin_sync_q[reg_addr[RA_W-1:1]]
                & port_mask(int'(reg_addr[RA_W-1:1])));
      end else begin
        rd_d = ddr_q[reg_addr[RA_W-1:1]];
      end
    end else if (reg_addr == REG_CTRL) begin
      rd_d = ctrl_q;
    end else if (reg_addr == REG_STATUS) begin
      rd_d[ST_RET_OK]  = ret_ok_q;
      rd_d[ST_REC_OK]  = rec_ok_q;
      rd_d[ST_HWSTBY]  = hw_standby_request_n;
      rd_d[ST_ADDRHLD] = (rs_q == RS_HOLD);
    end else if (reg_addr == REG_P7) begin
      rd_d = p7_sync_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // port pin state selection
  // ----------------------------------------------------------------
  logic [NPORT-1:0][PW-1:0] want_oe;
  logic [NPORT-1:0][PW-1:0] want_o;
  logic [NPORT-1:0][PW-1:0] keep_v;
  logic                     in_sw;
  logic                     in_br;
  logic                     x34;

  assign in_sw = !in_reset && (op_state == OP_SWSTBY);
  assign in_br = !in_reset && (op_state == OP_BUSREL);
  assign x34   = is_expanded34(mode);

  always_comb begin
    for (int k = 0; k < NPORT; k++) begin
      want_oe[k] = ddr_q[k] & port_mask(k);
      want_o[k]  = dr_q[k];
      keep_v[k]  = {PW{in_sw | in_br}} & port_mask(k);
    end
    if (bus16) begin
      want_oe[P_P4] = {PW{core_bus.data_oe & ~bus_float}};
      want_o[P_P4]  = core_bus.dout[7:0];
      keep_v[P_P4]  = '0;
    end
    if (bus_release_enable) begin
      want_oe[P_P6][BREQ_BIT] = 1'b0;
      want_oe[P_P6][BACK_BIT] = 1'b1;
      want_o[P_P6][BACK_BIT]  = ~in_br;
      keep_v[P_P6][BREQ_BIT]  = 1'b0;
      keep_v[P_P6][BACK_BIT]  = 1'b0;
    end
    if (in_sw) begin
      keep_v[P_P8][CS0_BIT:1] = '0;
      want_o[P_P8][CS0_BIT-1:1] = '1;
      want_o[P_P8][CS0_BIT]   = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (x34) begin
        keep_v[P_PA][PA_HI_LSB+i] = 1'b0;
        if (in_br) begin
          want_oe[P_PA][PA_HI_LSB+i] = ddr_q[P_PA][PA_HI_LSB+i] | timer_oe[i];
          want_o[P_PA][PA_HI_LSB+i]  = timer_oe[i] ? timer_out[i] : dr_q[P_PA][PA_HI_LSB+i];
        end else if (!in_sw && (i == 3 || !aen[i])) begin
          want_oe[P_PA][PA_HI_LSB+i] = 1'b1;
          want_o[P_PA][PA_HI_LSB+i]  = (i == 3) ? core_bus.addr[ADDR_W]
                                                : core_bus.addr[XADDR_W-PA_ADDR_BITS+i];
        end else if (!in_sw && timer_oe[i]) begin
          want_oe[P_PA][PA_HI_LSB+i] = 1'b1;
          want_o[P_PA][PA_HI_LSB+i]  = timer_out[i];
        end
      end
    end
  end

  logic [NPORT*PW-1:0] cell_oe;
  logic [NPORT*PW-1:0] cell_o;

  psc_keep_cell #(
    .W (NPORT * PW)
  ) u_keep (
    .clk       (clk),
    .rst_n     (rst_n),
    .keep      (keep_v),
    .float_all ({(NPORT * PW){in_reset | hw_standby_request_n}}),
    .oe_i      (want_oe),
    .o_i       (want_o),
    .oe_o      (cell_oe),
    .o_o       (cell_o)
  );

  // chip-select 0 is the one port pin that drives low through reset
  always_comb begin
    port_oe = cell_oe;
    port_o  = cell_o;
    if (in_reset && !hw_standby_request_n) begin
      port_oe[P_P8][CS0_BIT] = 1'b1;
      port_o[P_P8][CS0_BIT]  = 1'b0;
    end
  end

endmodule : psc_pin_state

//--- psc_pkg.sv
package psc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int RES_LEAD_CYCLES = 10;
  localparam int REC_LEAD_NS     = 100;
  localparam int REC_LEAD_CYC    = (REC_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LEAD_CNT_W      = 5;
  localparam logic [LEAD_CNT_W-1:0] LEAD_CNT_MAX = 5'h1f;
  localparam logic [LEAD_CNT_W-1:0] RES_LEAD_CNT = LEAD_CNT_W'(RES_LEAD_CYCLES);
  localparam logic [LEAD_CNT_W-1:0] REC_LEAD_CNT = LEAD_CNT_W'(REC_LEAD_CYC);

  // ----------------------------------------------------------------
  // port groups
  // ----------------------------------------------------------------
  localparam int NPORT   = 6;
  localparam int PW      = 8;
  localparam int P_P4    = 0;
  localparam int P_P6    = 1;
  localparam int P_P8    = 2;
  localparam int P_P9    = 3;
  localparam int P_PA    = 4;
  localparam int P_PB    = 5;
  localparam logic [PW-1:0] P4_MASK = 8'hff;
  localparam logic [PW-1:0] P6_MASK = 8'h07;
  localparam logic [PW-1:0] P8_MASK = 8'h1f;
  localparam logic [PW-1:0] P9_MASK = 8'h3f;
  localparam logic [PW-1:0] PA_MASK = 8'hff;
  localparam logic [PW-1:0] PB_MASK = 8'hff;
  localparam int WAIT_BIT     = 0;
  localparam int BREQ_BIT     = 1;
  localparam int BACK_BIT     = 2;
  localparam int CS0_BIT      = 4;
  localparam int PA_HI_LSB    = 4;
  localparam int PA_ADDR_BITS = 3;
  localparam int ADDR_W       = 20;
  localparam int XADDR_W      = 24;

  // ----------------------------------------------------------------
  // register map, indices on the plain register port
  // ----------------------------------------------------------------
  localparam int RA_W = 4;
  localparam int RD_W = 8;
  localparam logic [RA_W-1:0] REG_DDR_BASE = 4'h0;  // port k dir at 2k, data at 2k+1
  localparam logic [RA_W-1:0] REG_CTRL     = 4'hc;
  localparam logic [RA_W-1:0] REG_STATUS   = 4'hd;
  localparam logic [RA_W-1:0] REG_P7       = 4'he;
  localparam int CTRL_BUS_RELEASE_ENABLE    = 0;
  localparam int CTRL_ONCHIP_MEMORY_ENABLE    = 1;
  localparam int CTRL_AEN_LSB = 2;
  localparam logic [RD_W-1:0] CTRL_MASK  = 8'h1f;
  localparam logic [RD_W-1:0] CTRL_RESET = 8'h00;
  localparam int ST_RET_OK  = 0;
  localparam int ST_REC_OK  = 1;
  localparam int ST_HWSTBY  = 2;
  localparam int ST_ADDRHLD = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_RUN    = 2'b00,
    OP_SLEEP  = 2'b01,
    OP_SWSTBY = 2'b10,
    OP_BUSREL = 2'b11
  } psc_op_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_T1   = 3'b001,
    PH_T2   = 3'b010,
    PH_T3   = 3'b011,
    PH_TW   = 3'b100
  } psc_phase_t;

  typedef enum logic [1:0] {
    RS_RUN  = 2'b00,
    RS_HOLD = 2'b01,
    RS_LOW  = 2'b10
  } psc_rst_t;

  typedef struct packed {
    logic as_n;
    logic rd_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
  } psc_strobe_t;

  typedef struct packed {
    logic [XADDR_W-1:0] addr;
    logic [15:0]        dout;
    logic               data_oe;
    psc_strobe_t        strobe;
  } psc_bus_t;

endpackage : psc_pkg

//--- psc_keep_cell.sv
`timescale 1ns/1ps
module psc_keep_cell #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] keep,
  input  wire logic [W-1:0] float_all,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] o_i,
  output      logic [W-1:0] oe_o,
  output      logic [W-1:0] o_o
);

  logic [W-1:0] hold_oe_q;
  logic [W-1:0] hold_o_q;

  // last driven state is captured whenever a bit is not kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_oe_q <= '0;
      hold_o_q  <= '0;
    end else begin
      hold_oe_q <= (keep & hold_oe_q) | (~keep & oe_i & ~float_all);
      hold_o_q  <= (keep & hold_o_q)  | (~keep & o_i);
    end
  end

  // inputs had oe low when captured, so a kept input stays floating
  assign oe_o = ~float_all & ((keep & hold_oe_q) | (~keep & oe_i));
  assign o_o  = (keep & hold_o_q) | (~keep & o_i);

endmodule : psc_keep_cell

//--- psc_pin_state_monitor.sv
`timescale 1ns/1ps
module psc_pin_state_monitor
  import psc_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     chip_init_n,
  input wire logic                     standby_request_n,
  input wire logic [2:0]               mode,
  input psc_op_t                       op_state,
  input psc_phase_t                    bus_phase,
  input wire logic                     two_state_area,
  input wire logic                     watchdog_overflow,
  input wire logic [3:0]               timer_oe,
  input wire logic [3:0]               timer_out,
  input wire logic                     clk_out_oe,
  input wire logic                     watchdog_reset_out,
  input wire logic                     watchdog_reset_out_oe,
  input wire logic [ADDR_W-1:0]        addr_o,
  input wire logic                     addr_oe,
  input wire logic                     data_hi_oe,
  input psc_strobe_t                   strobe_o,
  input wire logic                     strobe_oe,
  input wire logic [NPORT-1:0][PW-1:0] port_o,
  input wire logic [NPORT-1:0][PW-1:0] port_oe
);
  // ----------------------------------------------------------------
  // pin state checks
  // ----------------------------------------------------------------
  // quiet: neither external pin active, so the sampled copies have settled
  logic quiet;
  assign quiet = chip_init_n && standby_request_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_init_ports_in: assert property (
    !chip_init_n |-> port_oe[P_P4] == 8'h00 && port_oe[P_P6] == 8'h00 && port_oe[P_P9] == 8'h00
      && port_oe[P_PA] == 8'h00 && port_oe[P_PB] == 8'h00 && port_oe[P_P8][3:0] == 4'h0)
    else $error("port pin driven while chip init is low");
  a_init_strobes: assert property (
    !chip_init_n |-> strobe_o == 4'hf && !data_hi_oe)
    else $error("strobes or data bus active while chip init is low");
  a_addr_low: assert property (
    $fell(chip_init_n) && !(bus_phase == PH_T3 || (bus_phase == PH_T2 && two_state_area))
      ##0 !chip_init_n [*4] |-> addr_o == '0)
    else $error("address not driven low after chip init");
  a_addr_hold: assert property (
    $fell(chip_init_n) && (bus_phase == PH_T3 || (bus_phase == PH_T2 && two_state_area))
      |=> addr_o == $past(addr_o))
    else $error("address not held in last access state");
  a_hw_float: assert property (
    !standby_request_n [*4] |-> !clk_out_oe && !addr_oe && !data_hi_oe && !strobe_oe
      && port_oe == '0 && !watchdog_reset_out_oe)
    else $error("pin driven in hardware standby");
  a_wdt_out: assert property (
    standby_request_n [*4] |-> watchdog_reset_out_oe == watchdog_overflow && !watchdog_reset_out)
    else $error("reset output does not follow watchdog overflow");
  a_busrel_float: assert property (
    chip_init_n && op_state == OP_BUSREL |-> !addr_oe && !data_hi_oe && !strobe_oe)
    else $error("bus pins driven while bus released");
  a_keep_hold: assert property (
    quiet [*4] ##0 op_state == OP_SWSTBY && $past(op_state) == OP_SWSTBY
      |-> port_o[P_P9] == $past(port_o[P_P9]) && port_oe[P_P9] == $past(port_oe[P_P9]))
    else $error("kept port changed in software standby");
  a_timer_pa: assert property (
    quiet [*4] ##0 op_state == OP_BUSREL && (mode == 3'h3 || mode == 3'h4)
      |-> (port_oe[P_PA][7:4] & timer_oe) == timer_oe
      && ((port_o[P_PA][7:4] ^ timer_out) & timer_oe) == 4'h0)
    else $error("upper port a ignores timer outputs in bus release");
endmodule : psc_pin_state_monitor

bind psc_pin_state psc_pin_state_monitor u_psc_mon (
  .clk(clk), .rst_n(rst_n), .chip_init_n(chip_init_n), .standby_request_n(standby_request_n),
  .mode(mode), .op_state(op_state), .bus_phase(bus_phase), .two_state_area(two_state_area),
  .watchdog_overflow(watchdog_overflow), .timer_oe(timer_oe), .timer_out(timer_out),
  .clk_out_oe(clk_out_oe), .watchdog_reset_out(watchdog_reset_out),
  .watchdog_reset_out_oe(watchdog_reset_out_oe), .addr_o(addr_o), .addr_oe(addr_oe),
  .data_hi_oe(data_hi_oe), .strobe_o(strobe_o), .strobe_oe(strobe_oe), .port_o(port_o),
  .port_oe(port_oe)
);

//--- psc_supervisor_model.sv
`timescale 1ns/1ps
module psc_supervisor_model
  import psc_pkg::*;
(
  input  wire logic clk,
  output      logic chip_init_n,
  output      logic standby_request_n
);
  // ----------------------------------------------------------------
  // reset and standby sequencing
  // ----------------------------------------------------------------
  initial begin
    chip_init_n       = 1'b1;
    standby_request_n = 1'b1;
  end

  task automatic set_init(input logic v);
    @(posedge clk);
    chip_init_n <= v;
  endtask : set_init

  // two spare cycles of lead: the device counts from its own sampled copy
  task automatic enter_standby(input logic retain);
    if (retain) begin
      set_init(1'b0);
      repeat (RES_LEAD_CYCLES + 2) @(posedge clk);
    end else begin
      @(posedge clk);
    end
    standby_request_n <= 1'b0;
    @(posedge clk);
    chip_init_n <= 1'b1;
  endtask : enter_standby

  task automatic leave_standby();
    set_init(1'b0);
    repeat (REC_LEAD_CYC + 4) @(posedge clk);
    standby_request_n <= 1'b1;
    repeat (4) @(posedge clk);
    chip_init_n <= 1'b1;
  endtask : leave_standby
endmodule : psc_supervisor_model

//--- psc_pin_state_tb.sv
`timescale 1ns/1ps
module psc_pin_state_tb
  import psc_pkg::*;
;
  logic                     clk, rst_n, bus16, two_state_area, watchdog_overflow;
  logic                     reg_we, reg_re, clk_out_oe, clk_out_hold_high;
  logic                     watchdog_reset_out, watchdog_reset_out_oe, addr_oe, data_hi_oe;
  logic                     strobe_oe;
  wire logic                chip_init_n, standby_request_n;
  logic [2:0]               mode;
  psc_op_t                  op_state;
  psc_phase_t               bus_phase;
  psc_bus_t                 core_bus;
  psc_strobe_t              strobe_o;
  logic [3:0]               timer_oe, timer_out;
  logic [RA_W-1:0]          reg_addr;
  logic [RD_W-1:0]          reg_wdata, reg_rdata, p7_i, rd;
  logic [ADDR_W-1:0]        addr_o;
  logic [7:0]               data_hi_o;
  logic [NPORT-1:0][PW-1:0] port_i, port_o, port_oe;
  int                       n_fail, n_compared;
  psc_phase_t               phases [4] = '{PH_T1, PH_TW, PH_T3, PH_T2};
  logic                     onchip_memory_enable [3] = '{1'b1, 1'b1, 1'b0};
  logic                     lead [3] = '{1'b1, 1'b0, 1'b0};

  psc_pin_state dut (
    .clk(clk), .rst_n(rst_n), .chip_init_n(chip_init_n), .standby_request_n(standby_request_n),
    .mode(mode), .bus16(bus16), .op_state(op_state), .bus_phase(bus_phase),
    .two_state_area(two_state_area), .core_bus(core_bus), .watchdog_overflow(watchdog_overflow),
    .timer_oe(timer_oe), .timer_out(timer_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .clk_out_oe(clk_out_oe),
    .clk_out_hold_high(clk_out_hold_high), .watchdog_reset_out(watchdog_reset_out),
    .watchdog_reset_out_oe(watchdog_reset_out_oe), .addr_o(addr_o), .addr_oe(addr_oe),
    .data_hi_o(data_hi_o), .data_hi_oe(data_hi_oe), .strobe_o(strobe_o), .strobe_oe(strobe_oe),
    .port_i(port_i), .port_o(port_o), .port_oe(port_oe), .p7_i(p7_i)
  );
  psc_supervisor_model sup (
    .clk(clk), .chip_init_n(chip_init_n), .standby_request_n(standby_request_n)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [RA_W-1:0] a, output logic [RD_W-1:0] d);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;  mode = 3'h3;  bus16 = 1'b1;  op_state = OP_RUN;  bus_phase = PH_IDLE;
    two_state_area = 1'b0;  core_bus = '0;  watchdog_overflow = 1'b0;  timer_oe = 4'h0;
    timer_out = 4'h0;  reg_addr = '0;  reg_wdata = '0;  reg_we = 1'b0;  reg_re = 1'b0;
    port_i = '0;  p7_i = 8'h3c;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_wr(4'h6, 8'hff);
    reg_wr(4'h7, 8'h15);
    reg_wr(4'h2, 8'hff);
    reg_rd(4'h6, rd);
    chk("p9 dir", P9_MASK, rd);
    reg_rd(4'h2, rd);
    chk("p6 dir", 8'h06, rd);
    reg_rd(4'hf, rd);
    chk("unmapped", 8'h00, rd);
    chk("p9 oe", P9_MASK, port_oe[P_P9]);
    reg_wr(4'h8, 8'hf0);
    reg_wr(4'h9, 8'ha0);
    reg_wr(REG_CTRL, 8'h1c);
    @(posedge clk) op_state <= OP_SWSTBY;
    reg_wr(4'h7, 8'h2a);
    reg_wr(4'h8, 8'h30);
    #1 chk("p9 kept", 8'h15, port_o[P_P9]);
    chk("pa hi oe sw", 8'h3, port_oe[P_PA][7:4]);
    chk("pa hi out sw", 8'h2, port_o[P_PA][5:4]);
    reg_wr(REG_CTRL, 8'h1d);
    @(posedge clk);
    op_state <= OP_BUSREL;
    timer_oe <= 4'h5;
    timer_out <= 4'h1;
    repeat (2) @(posedge clk);
    #1 chk("pa hi oe rel", 8'h7, port_oe[P_PA][7:4]);
    chk("pa hi out rel", 8'h3, port_o[P_PA][7:4] & 4'h7);
    chk("ack oe", 8'h1, port_oe[P_P6][BACK_BIT]);
    chk("ack level", 8'h0, port_o[P_P6][BACK_BIT]);
    chk("addr oe rel", 8'h0, addr_oe);
    @(posedge clk);
    op_state <= OP_RUN;
    timer_oe <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      bus_phase <= phases[i];
      two_state_area <= (i == 3);
      watchdog_overflow <= (i == 0);
      core_bus <= {24'h0abcde, 16'h1234, 1'b1, 4'h0};
      sup.set_init(1'b0);
      #1 chk("strobes", 8'hf, strobe_o);
      chk("data oe", 8'h0, data_hi_oe);
      chk("p9 oe init", 8'h00, port_oe[P_P9]);
      repeat (2) @(posedge clk);
      #1 chk("addr early", (i >= 2) ? 8'hde : 8'h00, addr_o[7:0]);
      repeat (3) @(posedge clk);
      #1 chk("addr nonzero", 8'h0, |addr_o);
      chk("addr oe", 8'h1, addr_oe);
      chk("wdt out oe", (i == 0), watchdog_reset_out_oe);
      sup.set_init(1'b1);
      watchdog_overflow <= 1'b0;
      repeat (3) @(posedge clk);
    end
    bus_phase <= PH_IDLE;
    core_bus <= '0;
    for (int i = 0; i < 3; i++) begin
      reg_wr(REG_CTRL, {6'h0, onchip_memory_enable[i], 1'b0});
      sup.enter_standby(lead[i]);
      repeat (5) @(posedge clk);
      #1 chk("clock oe", 8'h0, clk_out_oe);
      chk("ports oe", 8'h0, |port_oe);
      sup.leave_standby();
      repeat (4) @(posedge clk);
      reg_rd(REG_STATUS, rd);
      chk("status", {6'h0, 1'b1, lead[i] | !onchip_memory_enable[i]}, rd & 8'h07);
    end
    finish_test();
  end
endmodule : psc_pin_state_tb
